// ===== design/ctef_pkg.sv
// Constants, register map and field layout for the transmit event FIFO and extended filter block.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address and a single 25 MHz clock.
package ctef_pkg;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] IRQ_FLAGS_OFS = 12'h004;
  localparam logic [11:0] IRQ_MASK_OFS  = 12'h008;
  localparam logic [11:0] GFC_OFS       = 12'h00c;
  localparam logic [11:0] XIDFC_OFS     = 12'h010;
  localparam logic [11:0] XIDAM_OFS     = 12'h014;
  localparam logic [11:0] EF_STATUS_OFS = 12'h018;
  localparam logic [11:0] EF_ACK_OFS    = 12'h01c;
  localparam logic [11:0] FILT_BASE_OFS = 12'h040;
  localparam logic [11:0] TXEFC_OFS     = 12'h0f0;

  // Control register bits.
  localparam int CTRL_INIT_BIT = 0;
  localparam int CTRL_CCE_BIT  = 1;

  // Transmit event FIFO configuration fields.
  localparam int WM_LSB = 24;
  localparam int WM_W   = 6;
  localparam int FS_LSB = 16;
  localparam int FS_W   = 6;
  localparam int SA_LSB = 2;
  localparam int SA_W   = 14;
  localparam logic [31:0] TXEFC_RW_MASK = 32'h3f3f_fffc;
  localparam logic [5:0]  EF_MAX_ELEMS  = 6'h20;
  localparam logic [13:0] EF_ELEM_WORDS = 14'h0002;

  // Status register field positions.
  localparam int ST_FILL_LSB = 0;
  localparam int ST_GET_LSB  = 8;
  localparam int ST_PUT_LSB  = 16;
  localparam int ST_FULL_BIT = 24;

  // Interrupt flag bits.
  localparam int IRQ_W      = 4;
  localparam int IRQ_WM     = 0;
  localparam int IRQ_FULL   = 1;
  localparam int IRQ_LOST   = 2;
  localparam int IRQ_RX_ACC = 3;

  // Global filter configuration bits.
  localparam int GFC_REJ_NOMATCH = 0;
  localparam int GFC_REJ_REMOTE  = 1;

  // Extended filter list.
  localparam int NUM_FILT     = 4;
  localparam int FILT_EN_BIT  = 31;
  localparam int FILT_REJ_BIT = 30;

  // Reset values.
  localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
  localparam logic [31:0] TXEFC_RST = 32'h0000_0000;
  localparam logic [28:0] XIDAM_RST = 29'h1fff_ffff;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== design/ctef_filt_if.sv
// Carrier between the register block and the extended identifier filter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface ctef_filt_if;
  logic [28:0] and_mask;
  logic [2:0]  list_size;
  logic        rej_nomatch;
  logic        rej_remote;
  logic [31:0] elem_id   [ctef_pkg::NUM_FILT];
  logic [31:0] elem_mask [ctef_pkg::NUM_FILT];
  logic        rx_valid;
  logic [28:0] rx_id;
  logic        rx_rtr;
  logic        rx_ide;
  logic        res_valid;
  logic        res_accept;
  logic        res_hit;
  logic [1:0]  res_idx;

  modport cfg  (output and_mask, list_size, rej_nomatch, rej_remote, elem_id, elem_mask,
                output rx_valid, rx_id, rx_rtr, rx_ide,
                input res_valid, res_accept, res_hit, res_idx);
  modport filt (input and_mask, list_size, rej_nomatch, rej_remote, elem_id, elem_mask,
                input rx_valid, rx_id, rx_rtr, rx_ide,
                output res_valid, res_accept, res_hit, res_idx);
endinterface
`default_nettype wire

// ===== design/ctef_ext_filter.sv
// Extended identifier acceptance filter: masks the received identifier, walks the filter list.
// Assumes received frame fields come from logic on the same clock and are valid for one cycle.
`timescale 1ns/1ps
`default_nettype none
module ctef_ext_filter (
  input  wire logic aclk,
  input  wire logic aresetn,
  ctef_filt_if.filt f
);

  logic [28:0] masked_id;
  logic        hit;
  logic        rej;
  logic [1:0]  idx;
  logic        accept;

  assign masked_id = f.rx_id & f.and_mask;

  // First enabled matching element in list order wins, so earlier elements take priority.
  always_comb begin
    hit = 1'b0;
    rej = 1'b0;
    idx = 2'h0;
    for (int i = 0; i < ctef_pkg::NUM_FILT; i++) begin
      if (!hit && (3'(i) < f.list_size) && f.elem_id[i][ctef_pkg::FILT_EN_BIT] &&
          (((masked_id ^ f.elem_id[i][28:0]) & f.elem_mask[i][28:0]) == 29'h0000_0000)) begin
        hit = 1'b1;
        rej = f.elem_id[i][ctef_pkg::FILT_REJ_BIT];
        idx = 2'(i);
      end
    end
    accept = !(f.rx_rtr && f.rej_remote) && (hit ? !rej : !f.rej_nomatch);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f.res_valid  <= 1'b0;
      f.res_accept <= 1'b0;
      f.res_hit    <= 1'b0;
      f.res_idx    <= 2'h0;
    end else begin
      f.res_valid  <= f.rx_valid && f.rx_ide;
      f.res_accept <= f.rx_valid && f.rx_ide && accept;
      f.res_hit    <= hit;
      f.res_idx    <= idx;
    end
  end

  AST_FILT_IDE: assert property (@(posedge aclk) disable iff (!aresetn)
    f.rx_valid && !f.rx_ide |=> !f.res_valid)
    else $error("Standard frame produced a filter result.");

  AST_FILT_NOMATCH: assert property (@(posedge aclk) disable iff (!aresetn)
    f.rx_valid && f.rx_ide && !f.rx_rtr && f.list_size == 3'h0 |=> f.res_accept == !$past(f.rej_nomatch))
    else $error("Empty list did not follow the non-matching policy.");

  AST_FILT_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
    f.rx_valid && f.rx_ide && f.and_mask == 29'h0000_0000 && f.list_size != 3'h0 &&
    f.elem_id[0][31] && f.elem_id[0][28:0] == 29'h0000_0000 |=> f.res_hit && f.res_idx == 2'h0)
    else $error("Masked identifier did not hit element zero.");

  COV_FILT_HIT: cover property (@(posedge aclk) disable iff (!aresetn) f.res_valid && f.res_hit);

endmodule
`default_nettype wire

// ===== design/ctef_top.sv
// Transmit event FIFO configuration and control with extended identifier filtering, AXI4-Lite slave.
// Assumes a single clock; the transmit path and receive path sit on the same clock as this block.
// Operation
// - Configuration writes take effect only while change enable and init are both set; the code locks only TXEFC writes, other set-up writes always land.
// - Watermark level sits in bits 29:24; zero disables the watermark interrupt.
// - Watermark 1 to 32 sets the interrupt level; above 32 disables it.
// - Size sits in bits 21:16; zero disables the event FIFO.
// - Size 1 to 32 gives elements; larger sizes act as 32.
// - Elements are indexed from zero to size minus one.
// - Extended frames have identifier, RTR and IDE checked against the filter list; the code compares only the masked identifier with the list elements.
// - Received identifier is ANDed with the extended mask before filtering.
// - Global and extended filter settings govern extended filtering.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module ctef_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        tx_event_push,
  output logic             tx_event_wr_en,
  output logic [13:0]      tx_event_wr_addr,
  input  wire logic        rx_frame_valid,
  input  wire logic [28:0] rx_frame_id,
  input  wire logic        rx_frame_rtr,
  input  wire logic        rx_frame_ide,
  output logic             rx_accept_valid,
  output logic             rx_accept,
  output logic             rx_filter_hit,
  output logic [1:0]       rx_filter_idx,
  output logic             irq
);

  ctef_filt_if fif ();

  logic        aw_held_q, w_held_q, wr_do;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        ctrl_init_q, ctrl_cce_q;
  logic [31:0] txefc_q;
  logic [ctef_pkg::IRQ_W-1:0] ifl_q, imask_q, ifl_set;
  logic [1:0]  gfc_q;
  logic [2:0]  xidfc_q;
  logic [28:0] xidam_q;
  logic [31:0] felem_id_q   [ctef_pkg::NUM_FILT];
  logic [31:0] felem_mask_q [ctef_pkg::NUM_FILT];
  logic [5:0]  fill_q, fill_d;
  logic [4:0]  put_q, get_q;
  logic [5:0]  wm, size_raw, size_eff;
  logic [13:0] start_addr;
  logic        wm_en, cfg_unlocked, cfg_wr, push_ok, pop, ef_full;
  logic [31:0] rd_val;
  logic        rd_map;

  // Byte-lane merge so partial writes only touch the lanes offered.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic wr_hit(input logic [11:0] ofs);
    return wr_do && (awaddr_q[11:2] == ofs[11:2]);
  endfunction

  // Write channel: address and data are latched independently, so either may arrive first.
  assign awready = !aw_held_q && !bvalid;
  assign wready  = !w_held_q && !bvalid;
  assign wr_do   = aw_held_q && w_held_q && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= 12'h000;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_do) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (wr_do) begin
      w_held_q <= 1'b0;
    end
  end

  logic wr_map;
  always_comb begin
    wr_map = 1'b0;
    for (int i = 0; i < 2 * ctef_pkg::NUM_FILT; i++) begin
      if (wr_hit(12'(ctef_pkg::FILT_BASE_OFS + 12'(4 * i)))) begin
        wr_map = 1'b1;
      end
    end
    if (wr_hit(ctef_pkg::CTRL_OFS) || wr_hit(ctef_pkg::IRQ_FLAGS_OFS) || wr_hit(ctef_pkg::IRQ_MASK_OFS) ||
        wr_hit(ctef_pkg::GFC_OFS) || wr_hit(ctef_pkg::XIDFC_OFS) || wr_hit(ctef_pkg::XIDAM_OFS) ||
        wr_hit(ctef_pkg::EF_STATUS_OFS) || wr_hit(ctef_pkg::EF_ACK_OFS) || wr_hit(ctef_pkg::TXEFC_OFS)) begin
      wr_map = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= ctef_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid <= 1'b1;
      bresp  <= wr_map ? ctef_pkg::RESP_OKAY : ctef_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Plain control and filter set-up registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_init_q <= ctef_pkg::CTRL_RST[ctef_pkg::CTRL_INIT_BIT];
      ctrl_cce_q  <= ctef_pkg::CTRL_RST[ctef_pkg::CTRL_CCE_BIT];
      imask_q     <= '0;
      gfc_q       <= 2'h0;
      xidfc_q     <= 3'h0;
      xidam_q     <= ctef_pkg::XIDAM_RST;
      for (int i = 0; i < ctef_pkg::NUM_FILT; i++) begin
        felem_id_q[i]   <= 32'h0000_0000;
        felem_mask_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_hit(ctef_pkg::CTRL_OFS) && wstrb_q[0]) begin
        ctrl_init_q <= wdata_q[ctef_pkg::CTRL_INIT_BIT];
        ctrl_cce_q  <= wdata_q[ctef_pkg::CTRL_CCE_BIT];
      end
      if (wr_hit(ctef_pkg::IRQ_MASK_OFS) && wstrb_q[0]) begin
        imask_q <= wdata_q[ctef_pkg::IRQ_W-1:0];
      end
      if (wr_hit(ctef_pkg::GFC_OFS) && wstrb_q[0]) begin
        gfc_q <= wdata_q[1:0];
      end
      if (wr_hit(ctef_pkg::XIDFC_OFS) && wstrb_q[0]) begin
        xidfc_q <= wdata_q[2:0];
      end
      if (wr_hit(ctef_pkg::XIDAM_OFS)) begin
        xidam_q <= 29'(merge({3'h0, xidam_q}, wdata_q, wstrb_q));
      end
      for (int i = 0; i < ctef_pkg::NUM_FILT; i++) begin
        if (wr_hit(12'(ctef_pkg::FILT_BASE_OFS + 12'(8 * i)))) begin
          felem_id_q[i] <= merge(felem_id_q[i], wdata_q, wstrb_q);
        end
        if (wr_hit(12'(ctef_pkg::FILT_BASE_OFS + 12'(8 * i + 4)))) begin
          felem_mask_q[i] <= merge(felem_mask_q[i], wdata_q, wstrb_q);
        end
      end
    end
  end

  // The event FIFO set-up is locked while the controller runs, so a live FIFO never moves.
  assign cfg_unlocked = ctrl_cce_q && ctrl_init_q;
  assign cfg_wr       = wr_hit(ctef_pkg::TXEFC_OFS) && cfg_unlocked;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txefc_q <= ctef_pkg::TXEFC_RST;
    end else if (cfg_wr) begin
      txefc_q <= merge(txefc_q, wdata_q, wstrb_q) & ctef_pkg::TXEFC_RW_MASK;
    end
  end

  assign wm         = txefc_q[ctef_pkg::WM_LSB +: ctef_pkg::WM_W];
  assign size_raw   = txefc_q[ctef_pkg::FS_LSB +: ctef_pkg::FS_W];
  assign start_addr = txefc_q[ctef_pkg::SA_LSB +: ctef_pkg::SA_W];
  assign wm_en      = (wm != 6'h00) && (wm <= ctef_pkg::EF_MAX_ELEMS);
  assign size_eff   = (size_raw > ctef_pkg::EF_MAX_ELEMS) ? ctef_pkg::EF_MAX_ELEMS : size_raw;

  // Fill accounting; a zero size refuses every push.
  assign ef_full = (fill_q == size_eff);
  assign push_ok = tx_event_push && (size_eff != 6'h00) && !ef_full;
  assign pop     = wr_hit(ctef_pkg::EF_ACK_OFS) && (fill_q != 6'h00);

  always_comb begin
    fill_d = fill_q;
    if (push_ok && !pop) begin
      fill_d = 6'(fill_q + 6'h01);
    end else if (pop && !push_ok) begin
      fill_d = 6'(fill_q - 6'h01);
    end
  end

  // A configuration write empties the FIFO, keeping indices inside the new size.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_q <= 6'h00;
      put_q  <= 5'h00;
      get_q  <= 5'h00;
    end else if (cfg_wr) begin
      fill_q <= 6'h00;
      put_q  <= 5'h00;
      get_q  <= 5'h00;
    end else begin
      fill_q <= fill_d;
      if (push_ok) begin
        put_q <= ({1'b0, put_q} == 6'(size_eff - 6'h01)) ? 5'h00 : 5'(put_q + 5'h01);
      end
      if (pop) begin
        get_q <= ({1'b0, get_q} == 6'(size_eff - 6'h01)) ? 5'h00 : 5'(get_q + 5'h01);
      end
    end
  end

  // Element write strobe and word address go out registered for the message RAM.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_event_wr_en   <= 1'b0;
      tx_event_wr_addr <= 14'h0000;
    end else begin
      tx_event_wr_en <= push_ok;
      if (push_ok) begin
        tx_event_wr_addr <= 14'(start_addr + 14'(put_q) * ctef_pkg::EF_ELEM_WORDS);
      end
    end
  end

  // Interrupt flags: hardware set beats a same-cycle write-one clear.
  always_comb begin
    ifl_set = '0;
    ifl_set[ctef_pkg::IRQ_WM]     = wm_en && (fill_d == wm) && (fill_d != fill_q);
    ifl_set[ctef_pkg::IRQ_FULL]   = push_ok && (fill_d == size_eff);
    ifl_set[ctef_pkg::IRQ_LOST]   = tx_event_push && (size_eff != 6'h00) && ef_full;
    ifl_set[ctef_pkg::IRQ_RX_ACC] = fif.res_valid && fif.res_accept;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ifl_q <= '0;
    end else if (wr_hit(ctef_pkg::IRQ_FLAGS_OFS) && wstrb_q[0]) begin
      ifl_q <= (ifl_q & ~wdata_q[ctef_pkg::IRQ_W-1:0]) | ifl_set;
    end else begin
      ifl_q <= ifl_q | ifl_set;
    end
  end

  assign irq = |(ifl_q & imask_q);

  // Read channel answers one cycle after the address is taken.
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_map = 1'b1;
    unique case (araddr[11:2])
      ctef_pkg::CTRL_OFS[11:2]:      rd_val = {30'h0, ctrl_cce_q, ctrl_init_q};
      ctef_pkg::IRQ_FLAGS_OFS[11:2]: rd_val = 32'(ifl_q);
      ctef_pkg::IRQ_MASK_OFS[11:2]:  rd_val = 32'(imask_q);
      ctef_pkg::GFC_OFS[11:2]:       rd_val = 32'(gfc_q);
      ctef_pkg::XIDFC_OFS[11:2]:     rd_val = 32'(xidfc_q);
      ctef_pkg::XIDAM_OFS[11:2]:     rd_val = 32'(xidam_q);
      ctef_pkg::EF_STATUS_OFS[11:2]: begin
        rd_val[ctef_pkg::ST_FILL_LSB +: 6] = fill_q;
        rd_val[ctef_pkg::ST_GET_LSB +: 5]  = get_q;
        rd_val[ctef_pkg::ST_PUT_LSB +: 5]  = put_q;
        rd_val[ctef_pkg::ST_FULL_BIT]      = ef_full && (size_eff != 6'h00);
      end
      ctef_pkg::EF_ACK_OFS[11:2]:    rd_val = 32'h0000_0000;
      ctef_pkg::TXEFC_OFS[11:2]:     rd_val = txefc_q;
      default: begin
        rd_map = 1'b0;
        for (int i = 0; i < ctef_pkg::NUM_FILT; i++) begin
          if (araddr[11:2] == 10'(ctef_pkg::FILT_BASE_OFS[11:2] + 10'(2 * i))) begin
            rd_val = felem_id_q[i];
            rd_map = 1'b1;
          end
          if (araddr[11:2] == 10'(ctef_pkg::FILT_BASE_OFS[11:2] + 10'(2 * i + 1))) begin
            rd_val = felem_mask_q[i];
            rd_map = 1'b1;
          end
        end
      end
    endcase
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= ctef_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_map ? ctef_pkg::RESP_OKAY : ctef_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Filter hook-up.
  assign fif.and_mask    = xidam_q;
  assign fif.list_size   = xidfc_q;
  assign fif.rej_nomatch = gfc_q[ctef_pkg::GFC_REJ_NOMATCH];
  assign fif.rej_remote  = gfc_q[ctef_pkg::GFC_REJ_REMOTE];
  assign fif.elem_id     = felem_id_q;
  assign fif.elem_mask   = felem_mask_q;
  assign fif.rx_valid    = rx_frame_valid;
  assign fif.rx_id       = rx_frame_id;
  assign fif.rx_rtr      = rx_frame_rtr;
  assign fif.rx_ide      = rx_frame_ide;

  ctef_ext_filter u_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .f       (fif.filt)
  );

  assign rx_accept_valid = fif.res_valid;
  assign rx_accept       = fif.res_accept;
  assign rx_filter_hit   = fif.res_hit;
  assign rx_filter_idx   = fif.res_idx;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CFG_LOCK: assert property (wr_hit(ctef_pkg::TXEFC_OFS) && !cfg_unlocked |=> $stable(txefc_q))
    else $error("Locked configuration register changed.");
  AST_WM_DISABLED: assert property (!ifl_q[ctef_pkg::IRQ_WM] ##1 ifl_q[ctef_pkg::IRQ_WM] |-> $past(wm_en))
    else $error("Watermark flag set while watermark disabled.");
  AST_SIZE_ZERO: assert property (tx_event_push && size_raw == 6'h00 && !pop |=> $stable(fill_q) && !tx_event_wr_en)
    else $error("Push accepted with FIFO disabled.");
  AST_SIZE_CLAMP: assert property (size_raw > 6'h20 |-> fill_q <= 6'h20 && size_eff == 6'h20)
    else $error("Oversized FIFO size not treated as 32.");
  AST_PUT_RANGE: assert property (size_eff != 6'h00 |-> {1'b0, put_q} < size_eff && {1'b0, get_q} < size_eff)
    else $error("FIFO index outside programmed size.");
  AST_WM_SET: assert property (wm_en && push_ok && !pop && 6'(fill_q + 6'h01) == wm |=> ifl_q[ctef_pkg::IRQ_WM])
    else $error("Watermark reached without flag.");
  AST_WR_ADDR: assert property (push_ok |=> tx_event_wr_en &&
    tx_event_wr_addr == 14'($past(start_addr) + 14'($past(put_q)) * 14'h0002))
    else $error("Element address does not follow start address and index.");

  COV_WM: cover property (wm_en && ifl_set[ctef_pkg::IRQ_WM]);
  COV_WRAP: cover property (push_ok && put_q == 5'h00 && fill_q != 6'h00);
  COV_LOCKED_WR: cover property (wr_hit(ctef_pkg::TXEFC_OFS) && !cfg_unlocked);

endmodule
`default_nettype wire

// ===== verif/ctef_can_node.sv
// Model of the other CAN nodes: hands received frames to the block.
// Assumes the block samples the frame fields at the rising edge of aclk.
`timescale 1ns/1ps
`default_nettype none
module ctef_can_node (
  input  wire logic   aclk,
  output logic        valid,
  output logic [28:0] id,
  output logic        rtr,
  output logic        ide
);
  initial begin
    valid = 1'b0;
    id    = 29'h0000_0000;
    rtr   = 1'b0;
    ide   = 1'b0;
  end

  task automatic send(input logic [28:0] i, input logic r, input logic e);
    @(posedge aclk);
    valid <= 1'b1;
    id    <= i;
    rtr   <= r;
    ide   <= e;
    @(posedge aclk);
    valid <= 1'b0;
    // Stale fields show the inverse so a design that reads them late is caught.
    id    <= ~i;
    rtr   <= ~r;
    ide   <= ~e;
  endtask
endmodule
`default_nettype wire

// ===== verif/ctef_top_tb.sv
// Self-checking bench for ctef_top: AXI4-Lite master, event pushes and a CAN node model.
// Assumes the package ctef_pkg and the node model ctef_can_node are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module ctef_top_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, push;
  logic        awready, wready, bvalid, arready, rvalid, wr_en, fv, frtr, fide, acc_v, acc, hit, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp, idx;
  logic [13:0] wr_addr, sa;
  logic [28:0] fid, m, e, i;
  int          errors, n_tests, cyc, fill, eff, seed;
  int          fs_t[5] = '{0, 1, 5, 33, 40};
  int          wm_t[5] = '{1, 1, 3, 40, 32};

  ctef_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .tx_event_push(push), .tx_event_wr_en(wr_en),
    .tx_event_wr_addr(wr_addr), .rx_frame_valid(fv), .rx_frame_id(fid), .rx_frame_rtr(frtr),
    .rx_frame_ide(fide), .rx_accept_valid(acc_v), .rx_accept(acc), .rx_filter_hit(hit),
    .rx_filter_idx(idx), .irq(irq));
  ctef_can_node can (.aclk(aclk), .valid(fv), .id(fid), .rtr(frtr), .ide(fide));

  always #20 aclk = ~aclk;

  task automatic finish_test();
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(ha && hw)) begin
      @(negedge aclk);
      ha = ha || awready;
      hw = hw || wready;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    do @(negedge aclk); while (!bvalid);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rv   = rdata;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, push} = 6'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    seed = $urandom(32'h0000_eaa7);
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ctef_pkg::TXEFC_OFS);
    `CHK(rv, ctef_pkg::TXEFC_RST)
    rd(12'h3fc);
    `CHK(resp, ctef_pkg::RESP_SLVERR)
    v = $urandom;
    wr(ctef_pkg::TXEFC_OFS, v);
    rd(ctef_pkg::TXEFC_OFS);
    `CHK(rv, 32'h0000_0000)
    wr(ctef_pkg::CTRL_OFS, 32'h0000_0003);
    wr(ctef_pkg::TXEFC_OFS, v);
    rd(ctef_pkg::TXEFC_OFS);
    `CHK(rv, v & ctef_pkg::TXEFC_RW_MASK)
    for (int k = 0; k < 5; k++) begin
      sa = 14'($urandom);
      eff = fs_t[k] > 32 ? 32 : fs_t[k];
      fill = 0;
      wr(ctef_pkg::TXEFC_OFS, {2'b00, 6'(wm_t[k]), 2'b00, 6'(fs_t[k]), sa, 2'b00});
      wr(ctef_pkg::IRQ_FLAGS_OFS, 32'h0000_000f);
      repeat (eff + 1) begin
        @(posedge aclk);
        push <= 1'b1;
        @(posedge aclk);
        push <= 1'b0;
        @(negedge aclk);
        `CHK(wr_en, 1'(fill < eff))
        if (fill < eff) begin
          `CHK(wr_addr, 14'(sa + 2 * fill))
          fill++;
        end
      end
      rd(ctef_pkg::EF_STATUS_OFS);
      `CHK(rv[5:0], 6'(eff))
      rd(ctef_pkg::IRQ_FLAGS_OFS);
      `CHK(rv[0], 1'(wm_t[k] >= 1 && wm_t[k] <= 32 && wm_t[k] <= eff))
      `CHK(rv[2:1], {2{1'(eff > 0)}})
      wr(ctef_pkg::EF_ACK_OFS, 32'h0000_0000);
      rd(ctef_pkg::EF_STATUS_OFS);
      `CHK(rv[5:0], 6'(eff > 0 ? eff - 1 : 0))
      `CHK(rv[12:8], 5'(eff > 1))
    end
    m = 29'($urandom);
    e = 29'($urandom) & m;
    wr(ctef_pkg::XIDAM_OFS, {3'b000, m});
    wr(ctef_pkg::FILT_BASE_OFS, {3'b100, e});
    wr(ctef_pkg::FILT_BASE_OFS + 12'h004, 32'h1fff_ffff);
    wr(ctef_pkg::XIDFC_OFS, 32'h0000_0001);
    wr(ctef_pkg::GFC_OFS, 32'h0000_0001);
    wr(ctef_pkg::IRQ_MASK_OFS, 32'h0000_0008);
    wr(ctef_pkg::IRQ_FLAGS_OFS, 32'h0000_000f);
    for (int k = 0; k < 12; k++) begin
      i = k[0] ? 29'($urandom) : e | (29'($urandom) & ~m);
      can.send(i, 1'b0, 1'b1);
      @(negedge aclk);
      `CHK(acc_v, 1'b1)
      `CHK(acc, 1'((i & m) == e))
      `CHK(hit, 1'((i & m) == e))
      if ((i & m) == e) `CHK(idx, 2'h0)
    end
    @(negedge aclk);
    `CHK(irq, 1'b1)
    wr(ctef_pkg::IRQ_FLAGS_OFS, 32'h0000_0008);
    @(negedge aclk);
    `CHK(irq, 1'b0)
    can.send(e, 1'b0, 1'b0);
    @(negedge aclk);
    `CHK(acc_v, 1'b0)
    wr(ctef_pkg::GFC_OFS, 32'h0000_0003);
    can.send(e, 1'b1, 1'b1);
    @(negedge aclk);
    `CHK(acc, 1'b0)
    finish_test();
  end
endmodule
`default_nettype wire
